// file: hw/vpc_component_rom.sv
/*
 * Component memory: one registered read port for video, one write port
 * for reloading while running. Assumes pclk, clock enable, no reset on array.
 */
module vpc_component_rom
	import vpc_pkg::*;
#(
	parameter int AW = 11,
	parameter int DW = 9
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	vpc_rom_if.mem rom
);
	// Power-up contents zero, so reads before the first reload are defined
	logic [DW-1:0] mem_array [2**AW] = '{default: '0};
	logic [DW-1:0] rd_data_reg;

	// ----------------------------------------
	// Write port
	// ----------------------------------------
	always_ff @(posedge pclk)
	begin
		if (clk_en && rom.wr_en)
		begin
			mem_array[rom.wr_addr] <= rom.wr_data;
		end
	end

	// ----------------------------------------
	// Read port, one clock of latency
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_data_reg <= '0;
		end
		else if (clk_en)
		begin
			rd_data_reg <= mem_array[rom.rd_addr];
		end
	end

	assign rom.rd_data = rd_data_reg;

	a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && rom.wr_en ##1 clk_en && rom.rd_addr == $past(rom.wr_addr)
		|=> rd_data_reg == $past(rom.wr_data, 2))
		else $error("written component word not read back");
	a_read_latency: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !rom.wr_en |=> rd_data_reg == mem_array[$past(rom.rd_addr)])
		else $error("component read latency is not one clock");
endmodule : vpc_component_rom

// file: hw/vpc_pkg.sv
/*
 * Constants for the component output stage of the pattern generator.
 * Assumes a single sample clock and an APB register port.
 */
package vpc_pkg;
	// ----------------------------------------
	// Component memory shapes
	// ----------------------------------------
	localparam int VPC_NARROW_AW = 11;
	localparam int VPC_NARROW_DW = 9;
	localparam int VPC_WIDE_AW = 10;
	localparam int VPC_WIDE_DW = 18;
	localparam int VPC_MAX_AW = 11;
	localparam int VPC_MAX_DW = 18;
	localparam int VPC_REGION_W = 4;
	localparam int VPC_SAMPLE_W = 2;
	localparam int VPC_COMP_W = 10;
	localparam int VPC_FLAG_W = 3;
	// ----------------------------------------
	// Format limits
	// ----------------------------------------
	localparam logic [15:0] VPC_MAX_LINES = 16'h03FF;
	localparam logic [15:0] VPC_MAX_SAMPLES = 16'h0800;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] VPC_CTRL_OFS = 8'h00;
	localparam logic [7:0] VPC_STATUS_OFS = 8'h04;
	localparam logic [7:0] VPC_WADDR_OFS = 8'h08;
	localparam logic [7:0] VPC_WDATA_OFS = 8'h0C;
	localparam logic [7:0] VPC_LIMITS_OFS = 8'h10;
	localparam int VPC_CTRL_HOLD_BIT = 0;
	localparam logic [1:0] VPC_SAMPLE_RST = 2'h0;
	localparam logic [2:0] VPC_FLAG_RST = 3'h0;
	localparam logic [10:0] VPC_WADDR_RST = 11'h000;
endpackage : vpc_pkg

// file: hw/vpc_rom_if.sv
/*
 * Port bundle between the output stage and its component memory.
 * Assumes both ends share pclk.
 */
interface vpc_rom_if #(
	parameter int AW = 11,
	parameter int DW = 9
);
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	modport user (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
	modport mem (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : vpc_rom_if

// file: hw/vpc_top.sv
/*
 * Output stage of the memory-driven video pattern generator: forms the
 * component memory address, widens a nine-bit word to 10 bits or takes the low 10 bits of an 18-bit one, and delays the flags.
 * Assumes region codes and flags come from the state memories on pclk.
 */
// The APB slave port and the address map were left to the implementer.
// Notes on behaviour
// - Nine-bit memory word widened to ten bits by repeating its lowest bit.
// - Field, vertical and horizontal blanking flags delayed one clock in three bits.
// - Pattern select is an extra address bit choosing one of two palettes.
// - Wide variant: 1K by 18 memory, four-bit regions, no pattern select.
// - Formats limited to 1023 lines and 2048 samples per line.
// - Pattern changes by memory contents, including rewrites while running.
// - Address is sample counter, horizontal region and vertical region codes.
// - Vertical state memory gives field and vertical blanking bits per line.
module vpc_top
	import vpc_pkg::*;
#(
	parameter bit WIDE = 1'b0
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [VPC_REGION_W-1:0] h_region,
	input wire logic [VPC_REGION_W-1:0] v_region,
	input wire logic pattern_sel,
	input wire logic field_in,
	input wire logic vblank_in,
	input wire logic hblank_in,
	output logic [VPC_COMP_W-1:0] component,
	output logic field_out,
	output logic vblank_out,
	output logic hblank_out
);
	localparam int AW = WIDE ? VPC_WIDE_AW : VPC_NARROW_AW;
	localparam int DW = WIDE ? VPC_WIDE_DW : VPC_NARROW_DW;

	vpc_rom_if #(.AW(AW), .DW(DW)) rom_bus ();

	logic [VPC_SAMPLE_W-1:0] sample_reg;
	logic [VPC_FLAG_W-1:0] flag_reg;
	logic hold_reg;
	logic [VPC_MAX_AW-1:0] waddr_reg;
	logic [VPC_MAX_DW-1:0] word_pad;
	logic [VPC_MAX_AW-1:0] addr_full;
	logic acc;
	logic wr_hit;

	// ----------------------------------------
	// Sample counter
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sample_reg <= VPC_SAMPLE_RST;
		end
		else if (clk_en)
		begin
			sample_reg <= hold_reg ? VPC_SAMPLE_RST : sample_reg + 2'h1;
		end
	end

	// ----------------------------------------
	// Component memory address
	// ----------------------------------------
	always_comb
	begin
		if (WIDE)
		begin
			addr_full = {1'b0, v_region, h_region, sample_reg};
		end
		else
		begin
			addr_full = {pattern_sel, v_region, h_region, sample_reg};
		end
	end

	assign rom_bus.rd_addr = addr_full[AW-1:0];

	vpc_component_rom #(.AW(AW), .DW(DW)) u_component_rom (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.rom(rom_bus.mem)
	);

	// ----------------------------------------
	// Component widening
	// ----------------------------------------
	assign word_pad = VPC_MAX_DW'(rom_bus.rd_data);
	assign component = WIDE ? word_pad[VPC_COMP_W-1:0]
		: {word_pad[VPC_NARROW_DW-1:0], word_pad[0]};

	// ----------------------------------------
	// Flag delay
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_reg <= VPC_FLAG_RST;
		end
		else if (clk_en)
		begin
			flag_reg <= {field_in, vblank_in, hblank_in};
		end
	end

	assign field_out = flag_reg[2];
	assign vblank_out = flag_reg[1];
	assign hblank_out = flag_reg[0];

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	function automatic logic reg_wr(input logic hit, input logic [7:0] addr,
		input logic [7:0] ofs);
		return hit && addr == ofs;
	endfunction : reg_wr

	assign acc = psel && penable && clk_en;
	assign pready = clk_en;
	assign wr_hit = reg_wr(acc && pwrite, paddr, VPC_WDATA_OFS);
	assign rom_bus.wr_en = wr_hit;
	assign rom_bus.wr_addr = waddr_reg[AW-1:0];
	assign rom_bus.wr_data = pwdata[DW-1:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_reg <= 1'b0;
		end
		else if (reg_wr(acc && pwrite, paddr, VPC_CTRL_OFS))
		begin
			hold_reg <= pwdata[VPC_CTRL_HOLD_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			waddr_reg <= VPC_WADDR_RST;
		end
		else if (reg_wr(acc && pwrite, paddr, VPC_WADDR_OFS))
		begin
			waddr_reg <= pwdata[VPC_MAX_AW-1:0];
		end
		else if (wr_hit)
		begin
			waddr_reg <= waddr_reg + 11'h001;
		end
	end

	always_comb
	begin
		prdata = '0;
		pslverr = 1'b0;
		if (psel && penable)
		begin
			unique case (paddr)
				VPC_CTRL_OFS: prdata = 32'(hold_reg);
				VPC_STATUS_OFS: prdata = 32'({component, flag_reg, sample_reg});
				VPC_WADDR_OFS: prdata = 32'(waddr_reg);
				VPC_WDATA_OFS: prdata = '0;
				VPC_LIMITS_OFS: prdata = {VPC_MAX_SAMPLES, VPC_MAX_LINES};
				default: pslverr = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_lsb_repeat: assert property (@(posedge pclk) disable iff (!presetn)
		!WIDE |-> component[1:0] == {2{rom_bus.rd_data[0]}})
		else $error("component low bits not a copy of memory lsb");
	a_flag_delay: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> {field_out, vblank_out, hblank_out}
			== $past({field_in, vblank_in, hblank_in}))
		else $error("flags not delayed by one clock");
	a_pattern_bit: assert property (@(posedge pclk) disable iff (!presetn)
		!WIDE |-> addr_full[VPC_MAX_AW-1] == pattern_sel)
		else $error("pattern select not on top address bit");
	a_wide_addr: assert property (@(posedge pclk) disable iff (!presetn)
		WIDE |-> rom_bus.rd_addr == AW'({v_region, h_region, sample_reg}))
		else $error("wide address malformed");
	a_addr_fields: assert property (@(posedge pclk) disable iff (!presetn)
		addr_full[5:0] == {h_region, sample_reg})
		else $error("address low fields wrong");
	a_sample_step: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !hold_reg |=> sample_reg == $past(sample_reg) + 2'h1)
		else $error("sample counter did not advance");
	a_aligned_out: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !rom_bus.wr_en |=> flag_reg == $past({field_in, vblank_in, hblank_in})
			&& rom_bus.rd_data == u_component_rom.mem_array[$past(rom_bus.rd_addr)])
		else $error("flags and component not aligned");
	a_limits_read: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && paddr == VPC_LIMITS_OFS |-> prdata[15:0] == VPC_MAX_LINES && !pslverr)
		else $error("format limits misreported");
	a_clk_freeze: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(flag_reg) && $stable(sample_reg) && $stable(hold_reg))
		else $error("state changed while clock enable low");
	a_hold_zero: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && hold_reg |=> sample_reg == VPC_SAMPLE_RST)
		else $error("sample counter not held at zero");
	a_waddr_step: assert property (@(posedge pclk) disable iff (!presetn)
		wr_hit |=> waddr_reg == $past(waddr_reg) + 11'h001)
		else $error("write address did not advance");
endmodule : vpc_top

// file: verification/testbench.sv
/*
 * Self-checking bench for vpc_top over APB and the video stream.
 * Assumes the package and design files are compiled first.
 */
module testbench;
	import vpc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic pattern_sel = 0, er;
	logic [2:0] fl = 0, prev = 0, pp = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [3:0] h_region = 0, v_region = 0;
	logic [31:0] prdata;
	logic pready, pslverr, field_out, vblank_out, hblank_out;
	logic [9:0] component, component_w;
	logic [12:0] sink_word;
	logic [8:0] ws [4] = '{9'h155, 9'h0AA, 9'h1FF, 9'h002};
	int fails = 0, n_checks = 0, s;
	vpc_top #(.WIDE(1'b0)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .h_region(h_region),
		.v_region(v_region), .pattern_sel(pattern_sel), .field_in(fl[2]),
		.vblank_in(fl[1]), .hblank_in(fl[0]), .component(component),
		.field_out(field_out), .vblank_out(vblank_out), .hblank_out(hblank_out));
	vpc_top #(.WIDE(1'b1)) u_dut_wide (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(), .h_region(h_region),
		.v_region(v_region), .pattern_sel(pattern_sel), .field_in(fl[2]),
		.vblank_in(fl[1]), .hblank_in(fl[0]), .component(component_w),
		.field_out(), .vblank_out(), .hblank_out());
	vpc_sink u_sink (.pclk(pclk), .presetn(presetn), .component(component),
		.flags({field_out, vblank_out, hblank_out}), .word_reg(sink_word));
	initial
	begin
		forever #10 pclk = ~pclk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			fails++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task mw(input logic [10:0] a, input logic [8:0] w);
		apb(1'b1, VPC_WADDR_OFS, {21'h0, a});
		apb(1'b1, VPC_WDATA_OFS, {23'h0, w});
	endtask : mw
	function automatic logic [9:0] wd(input logic [8:0] w);
		return {w, w[0]};
	endfunction : wd
	task settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(1'b0, VPC_CTRL_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, VPC_WADDR_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, VPC_LIMITS_OFS, 32'h0);
		chk(rd, 32'h0800_03FF);
		apb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		$display("registers done");
		for (int i = 0; i < 4; i++)
			mw(i[10:0], ws[i]);
		apb(1'b1, VPC_CTRL_OFS, 32'h0);
		settle();
		s = 0;
		for (int i = 0; i < 4; i++)
			if (component === wd(ws[i]))
				s = i;
		for (int k = 1; k < 9; k++)
		begin
			@(posedge pclk);
			#1;
			chk(32'(component), 32'(wd(ws[(s + k) % 4])));
			chk(32'(component_w), 32'(ws[(s + k) % 4]));
		end
		$display("sample order done");
		apb(1'b1, VPC_CTRL_OFS, 32'h1);
		h_region <= 4'h5;
		v_region <= 4'hA;
		mw(11'h294, 9'h101);
		mw(11'h694, 9'h0FE);
		settle();
		chk(32'(component), 32'h203);
		chk(32'(component_w), 32'h0FE);
		@(posedge pclk);
		pattern_sel <= 1'b1;
		settle();
		chk(32'(component), 32'h1FC);
		chk(32'(component_w), 32'h0FE);
		mw(11'h694, 9'h1FF);
		settle();
		chk(32'(component), 32'h3FF);
		chk(32'(component_w), 32'h1FF);
		chk(32'(sink_word), 32'h03FF);
		apb(1'b0, VPC_STATUS_OFS, 32'h0);
		chk(rd, 32'h7FE0);
		$display("palette done");
		for (int i = 0; i < 9; i++)
		begin
			@(posedge pclk);
			pp = prev;
			prev = fl;
			fl <= 3'(i * 5);
			#1;
			chk(32'({field_out, vblank_out, hblank_out}), 32'(prev));
			chk(32'(sink_word[12:10]), 32'(pp));
		end
		@(posedge pclk);
		clk_en <= 1'b0;
		fl <= 3'h6;
		repeat (3) @(posedge pclk);
		#1;
		chk(32'({field_out, vblank_out, hblank_out}), 32'h0);
		chk(32'(pready), 32'h0);
		@(posedge pclk);
		clk_en <= 1'b1;
		@(posedge pclk);
		#1;
		chk(32'({field_out, vblank_out, hblank_out}), 32'h6);
		$display("flags done");
		summarize();
	end
endmodule : testbench

// file: verification/vpc_sink.sv
/*
 * Downstream encoder model: takes one component word and its flags per clock.
 * Assumes the sample clock and reset of the output stage.
 */
module vpc_sink
	import vpc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [VPC_COMP_W-1:0] component,
	input wire logic [VPC_FLAG_W-1:0] flags,
	output logic [VPC_COMP_W+VPC_FLAG_W-1:0] word_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Word capture
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			word_reg <= '0;
		else
			word_reg <= {flags, component};
	end
endmodule : vpc_sink
